// ===== lhe_exception_handler.sv
/*
  Exception handling for a balanced link: disconnected-mode answers,
  frame reject detection and reason field, busy signalling, sequence
  error, reject and time-out recovery.
  Assumes valid, error-free frames arrive already decoded on the same
  clock; framing, FCS, addressing and timers sit in other blocks.
*/
// What this block does
// - Disconnected: unusable mode command gets DM, no info
// - Disconnected: polled non-SABM command gets DM F=1
// - Undefined control, long info, bad N(R) reject
// - Bad length, stray F, UA/DM, bad N(S) reject
// - N(R) valid between oldest unacked and V(S)/x
// - N(S) invalid at last N(R)+k equal V(R)
// - Reason field 3 or 5 octets after control
// - Length or forbidden info sets W and X
// - Stray F, UA/DM, bad N(S) set W
// - Busy sends RNR, I frames may continue
// - Busy end shown by RR, REJ, UA
// - Modulo 8 reason field bit layout
// - Modulo 8 bits 9, 21-24 zero
// - Modulo 128 reason field bit layout
// - Modulo 128 unnumbered control in bits 1-8
// - C/R is one for rejected responses
// - Y long info, Z bad N(R), X needs W
// - Out-of-sequence info discarded, V(R) holds
// - Sequence-error frames still give N(R), P/F
// - One sent reject at a time, cleared on arrival
// - Received REJ restarts sending from its N(R)
// - Time-out with unacked frames starts recovery
// - Reject condition refuses I/S except P bit and bad N(R)
module lhe_exception_handler
  import lhe_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rx_valid_i,
  input wire lhe_rx_frame_s rx_frame_i,
  input wire logic t1_expire_i,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output lhe_tx_frame_s tx_frame_o,
  output logic rx_accept_o,
  output logic resend_o,
  output logic [6:0] resend_ns_o
);

  // ==========================================================
  // Register slave
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] ctrl_q;
  logic [6:0] vs_q, va_q, vr_q, x_q, last_nr_q;
  logic trec_q, frmr_q, rej_sent_q, busy_rep_q, peer_busy_q, p_out_q;
  logic [31:0] stat_w, rd_mux;
  logic wr_take, cmd_isent, cmd_frclr;

  assign wr_take = avs_write_i & ~wait_q;
  assign cmd_isent = wr_take & (avs_address_i == LHE_REG_CMD) &
                     avs_writedata_i[LHE_CMD_ISENT];
  assign cmd_frclr = wr_take & (avs_address_i == LHE_REG_CMD) &
                     avs_writedata_i[LHE_CMD_FRCLR];
  assign stat_w = {3'h0, peer_busy_q, busy_rep_q, trec_q, rej_sent_q,
                   frmr_q, 1'b0, va_q, 1'b0, vr_q, 1'b0, vs_q};
  assign rd_mux = (avs_address_i == LHE_REG_CTRL) ? ctrl_q :
                  (avs_address_i == LHE_REG_STAT) ? stat_w : 32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((avs_read_i | avs_write_i) & wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= avs_read_i ? rd_mux : 32'h0000_0000;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q <= LHE_CTRL_RESET;
    end else if (wr_take & (avs_address_i == LHE_REG_CTRL)) begin
      ctrl_q <= avs_writedata_i;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  // ==========================================================
  // Received frame decode
  logic m128, linked, busy;
  logic [6:0] mask, k, ns, nr, top, ns_lim;
  logic [15:0] c;
  logic [7:0] ucode;
  logic is_i, is_s, is_u, pf, resp, cmd;
  logic u_sabm, u_disc, u_ua, u_dm, u_frmr, undef;

  assign m128 = ctrl_q[LHE_CTRL_MOD128];
  assign linked = ctrl_q[LHE_CTRL_LINKED];
  assign busy = ctrl_q[LHE_CTRL_BUSY];
  assign k = ctrl_q[LHE_CTRL_K_LSB +: 7];
  assign mask = m128 ? LHE_MASK128 : LHE_MASK8;
  assign c = rx_frame_i.ctrl;
  assign resp = rx_frame_i.is_resp;
  assign cmd = ~rx_frame_i.is_resp;
  assign is_i = ~c[0];
  assign is_s = (c[1:0] == 2'h1);
  assign is_u = (c[1:0] == 2'h3);
  assign ucode = c[7:0] & LHE_U_PF_MASK;
  assign pf = (m128 & ~is_u) ? c[8] : c[4];
  assign ns = m128 ? c[7:1] : {4'h0, c[3:1]};
  assign nr = m128 ? c[15:9] : {4'h0, c[7:5]};
  assign u_sabm = is_u & (ucode == LHE_U_SABM);
  assign u_disc = is_u & (ucode == LHE_U_DISC);
  assign u_ua = is_u & (ucode == LHE_U_UA);
  assign u_dm = is_u & (ucode == LHE_U_DM);
  assign u_frmr = is_u & (ucode == LHE_U_FRMR);
  assign undef = (is_s & ((c[3:2] == 2'h3) | (m128 & (|c[7:4])))) |
                 (is_u & ~(u_sabm | u_disc | u_ua | u_dm | u_frmr));

  // ==========================================================
  // Frame reject checks
  logic nr_ok, ns_bad, info_bad, too_long, f_bad, unexp, rej_new;
  logic c_w, c_x, c_y, c_z;

  assign top = trec_q ? x_q : vs_q;
  assign nr_ok = ((nr - va_q) & mask) <= ((top - va_q) & mask);
  assign ns_lim = (last_nr_q + k) & mask;
  assign ns_bad = is_i & (ns == ns_lim) & (ns == vr_q);
  assign info_bad = (rx_frame_i.has_info & (is_s | (is_u & ~u_frmr))) |
                    (rx_frame_i.len_bad & ~is_i);
  assign too_long = is_i & rx_frame_i.info_long;
  assign f_bad = is_s & resp & pf & ~trec_q & ~p_out_q;
  assign unexp = resp & (u_ua | u_dm);
  assign c_z = (is_i | is_s) & ~nr_ok & ~undef;
  assign c_y = too_long & ~undef;
  assign c_x = info_bad & ~undef;
  assign c_w = undef | c_x | f_bad | unexp | ns_bad;
  assign rej_new = rx_valid_i & linked & ~frmr_q &
                   (c_w | c_y | c_z);

  // Reason field; bit n of the field is info[n-1]
  logic [39:0] r_info;
  logic [15:0] r_ctl;
  assign r_ctl = (is_u | ~m128) ? {8'h00, c[7:0]} : c;
  assign r_info = m128 ?
    {4'h0, c_z, c_y, c_x, c_w, vr_q, resp, vs_q, 1'b0, r_ctl} :
    {16'h0000, 4'h0, c_z, c_y, c_x, c_w, vr_q[2:0], resp,
     vs_q[2:0], 1'b0, r_ctl[7:0]};

  // ==========================================================
  // Normal frame handling
  logic go, in_seq, seq_err, rej_rx, trec_end, poll, sabm_ok, dm_req;
  logic timeout, isent_ok, nr_use, fr_again;

  assign go = rx_valid_i & linked & ~frmr_q & ~rej_new & (is_i | is_s);
  assign in_seq = go & is_i & (ns == vr_q) & ~busy;
  assign seq_err = go & is_i & (ns != vr_q);
  assign nr_use = go;
  assign rej_rx = go & is_s & (c[3:2] == LHE_S_REJ) & ~trec_q;
  assign trec_end = go & is_s & resp & pf & trec_q;
  assign poll = go & cmd & pf;
  // Reject condition: I and S frames only looked at for the P bit and a bad N(R)
  assign fr_again = rx_valid_i & linked & frmr_q & (is_i | is_s) &
                    ((cmd & pf) | ~nr_ok);
  assign sabm_ok = rx_valid_i & linked & cmd & u_sabm;
  // Link set-up is elsewhere, so a mode command here cannot be acted on
  assign dm_req = rx_valid_i & ~linked & cmd &
                  (u_sabm | u_disc | pf);
  assign timeout = t1_expire_i & linked & ((vs_q != va_q) | trec_q);
  assign isent_ok = cmd_isent & ~trec_q &
                    (((vs_q - va_q) & mask) < k);

  // ==========================================================
  // Transmit selection
  logic pend_ua_q, pend_dm_q, pend_fr_q, pend_s_q, pend_enq_q, pend_f_q;
  logic rej_need_q;
  logic free, issue, sel_ua, sel_dm, sel_fr, sel_s, sel_enq;
  logic [1:0] stype;
  logic [7:0] ubase;
  logic [15:0] s_ctl, u_ctl;
  logic s_pf, fr_ret;
  logic [39:0] frmr_info_q;

  assign free = ~tx_valid_o | tx_ready_i;
  assign sel_ua = pend_ua_q;
  assign sel_dm = ~pend_ua_q & pend_dm_q;
  assign sel_fr = ~pend_ua_q & ~pend_dm_q & pend_fr_q;
  assign sel_s = ~pend_ua_q & ~pend_dm_q & ~pend_fr_q & pend_s_q;
  assign sel_enq = ~pend_ua_q & ~pend_dm_q & ~pend_fr_q & ~pend_s_q &
                   pend_enq_q;
  assign issue = free & (sel_ua | sel_dm | sel_fr | sel_s | sel_enq);
  assign stype = busy ? LHE_S_RNR :
                 (rej_need_q & ~rej_sent_q) ? LHE_S_REJ : LHE_S_RR;
  assign s_pf = sel_enq | pend_f_q;
  assign s_ctl = m128 ? {vr_q, s_pf, 4'h0, stype, 2'h1} :
                 {8'h00, vr_q[2:0], s_pf, stype, 2'h1};
  assign ubase = sel_ua ? LHE_U_UA : sel_dm ? LHE_U_DM : LHE_U_FRMR;
  assign u_ctl = {8'h00, ubase[7:5], pend_f_q, ubase[3:0]};
  assign fr_ret = issue & sel_fr;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_valid_o <= 1'b0;
      tx_frame_o <= '0;
    end else if (issue) begin
      tx_valid_o <= 1'b1;
      tx_frame_o.ctrl <= (sel_s | sel_enq) ? s_ctl : u_ctl;
      tx_frame_o.is_cmd <= sel_enq;
      // DM and UA never carry information
      tx_frame_o.info <= sel_fr ? frmr_info_q : 40'h00_0000_0000;
      tx_frame_o.info_len <= ~sel_fr ? 3'h0 :
                             m128 ? LHE_FRLEN128 : LHE_FRLEN8;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // ==========================================================
  // Pending answers; a new event beats the clear of its flag, except a busy change
  logic busy_chg;
  assign busy_chg = linked & (busy != busy_rep_q);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pend_ua_q <= 1'b0;
      pend_dm_q <= 1'b0;
      pend_fr_q <= 1'b0;
      pend_s_q <= 1'b0;
      pend_enq_q <= 1'b0;
      pend_f_q <= 1'b0;
    end else begin
      pend_ua_q <= (pend_ua_q & ~(issue & sel_ua)) | sabm_ok;
      pend_dm_q <= (pend_dm_q & ~(issue & sel_dm)) | dm_req;
      pend_fr_q <= (pend_fr_q & ~fr_ret & ~sabm_ok) | rej_new |
                   fr_again;
      pend_s_q <= (pend_s_q & ~(issue & sel_s)) | in_seq | seq_err |
                  poll | (busy_chg & ~(issue & sel_s));
      pend_enq_q <= (pend_enq_q & ~(issue & sel_enq)) | timeout;
      pend_f_q <= (pend_f_q & ~(issue & ~sel_enq)) |
                  (rx_valid_i & cmd & pf & ~is_u) | poll |
                  ((sabm_ok | dm_req) & pf);
    end
  end

  // ==========================================================
  // Reject, busy and poll conditions
  logic s_out;
  assign s_out = issue & sel_s;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | ((sabm_ok | cmd_frclr) & ~rej_new)) begin
      frmr_q <= 1'b0;
      frmr_info_q <= 40'h00_0000_0000;
    end else if (rej_new) begin
      frmr_q <= 1'b1;
      frmr_info_q <= r_info;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | sabm_ok) begin
      rej_sent_q <= 1'b0;
      rej_need_q <= 1'b0;
    end else begin
      rej_need_q <= (rej_need_q & ~in_seq) | (seq_err & ~rej_sent_q);
      rej_sent_q <= (rej_sent_q & ~in_seq) |
                    (s_out & (stype == LHE_S_REJ));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_rep_q <= 1'b0;
      peer_busy_q <= 1'b0;
      p_out_q <= 1'b0;
    end else begin
      if (issue & (sel_ua | ((sel_s | sel_enq) & ~busy))) begin
        busy_rep_q <= 1'b0;
      end else if ((sel_s | sel_enq) & issue & busy) begin
        busy_rep_q <= 1'b1;
      end
      if (go & is_s) begin
        peer_busy_q <= (c[3:2] == LHE_S_RNR);
      end
      p_out_q <= (p_out_q & ~(go & resp & pf)) | (issue & sel_enq);
    end
  end

  // ==========================================================
  // Sequence state variables
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | sabm_ok) begin
      vs_q <= 7'h00;
      va_q <= 7'h00;
      vr_q <= 7'h00;
      x_q <= 7'h00;
      trec_q <= 1'b0;
      last_nr_q <= 7'h00;
    end else begin
      if (nr_use & nr_ok) begin
        va_q <= nr;
      end
      if (rej_rx & nr_ok) begin
        vs_q <= nr;
      end else if (trec_end & nr_ok) begin
        vs_q <= nr;
        trec_q <= 1'b0;
      end else if (timeout & ~trec_q) begin
        x_q <= vs_q;
        trec_q <= 1'b1;
      end else if (isent_ok) begin
        vs_q <= (vs_q + 7'h01) & mask;
      end
      if (in_seq) begin
        vr_q <= (vr_q + 7'h01) & mask;
      end
      if (s_out | isent_ok) begin
        last_nr_q <= vr_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_accept_o <= 1'b0;
      resend_o <= 1'b0;
      resend_ns_o <= 7'h00;
    end else begin
      rx_accept_o <= in_seq;
      resend_o <= (rej_rx | trec_end) & nr_ok;
      if ((rej_rx | trec_end) & nr_ok) begin
        resend_ns_o <= nr;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_dm_no_info: assert property (
    tx_valid_o && ((tx_frame_o.ctrl[7:0] & LHE_U_PF_MASK) == LHE_U_DM)
    |-> tx_frame_o.info_len == 3'h0)
    else $error("DM sent with information");
  a_dm_poll_ans: assert property (
    rx_valid_i && !linked && cmd && pf |=> pend_dm_q && pend_f_q)
    else $error("Polled command in disconnected phase unanswered");
  a_undef_rejects: assert property (
    rx_valid_i && linked && !frmr_q && undef
    |=> frmr_q && pend_fr_q && frmr_info_q[m128 ? 32 : 16])
    else $error("Undefined control did not raise reject");
  a_frmr_length: assert property (
    tx_valid_o && ((tx_frame_o.ctrl[7:0] & LHE_U_PF_MASK) == LHE_U_FRMR)
    |-> tx_frame_o.info_len == (m128 ? LHE_FRLEN128 : LHE_FRLEN8))
    else $error("Reject reason field has wrong length");
  a_x_with_w: assert property (
    frmr_q && (m128 ? frmr_info_q[33] : frmr_info_q[17])
    |-> (m128 ? frmr_info_q[32] : frmr_info_q[16]))
    else $error("X flag set without W");
  a_zero_bits8: assert property (
    frmr_q && !m128 |-> !frmr_info_q[8] && frmr_info_q[39:20] == '0)
    else $error("Reserved reason bits not zero");
  a_vr_holds: assert property (
    seq_err |=> $stable(vr_q) && !rx_accept_o)
    else $error("V(R) moved on a sequence error");
  a_one_rej: assert property (
    issue && sel_s && stype == LHE_S_REJ |-> !rej_sent_q ##1 rej_sent_q)
    else $error("Second reject raised");
  a_rej_resend: assert property (
    rej_rx && nr_ok |=> resend_o && resend_ns_o == $past(nr) &&
    vs_q == $past(nr))
    else $error("Reject did not restart sending");

endmodule

// ===== lhe_pkg.sv
/*
  Constants, field layouts and frame carriers shared by the link-layer
  exception handler.
  Assumes a single clock domain and one register slave per instance.
*/
package lhe_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] LHE_REG_CTRL = 4'h0;
  localparam logic [3:0] LHE_REG_STAT = 4'h4;
  localparam logic [3:0] LHE_REG_CMD = 4'h8;

  // ==========================================================
  // Control register fields and reset value
  localparam int LHE_CTRL_MOD128 = 0;
  localparam int LHE_CTRL_LINKED = 1;
  localparam int LHE_CTRL_BUSY = 2;
  localparam int LHE_CTRL_K_LSB = 8;
  localparam logic [31:0] LHE_CTRL_RESET = 32'h0000_0700;

  // ==========================================================
  // Command register fields
  localparam int LHE_CMD_ISENT = 0;
  localparam int LHE_CMD_FRCLR = 1;

  // ==========================================================
  // Sequence masks and reason field lengths in octets
  localparam logic [6:0] LHE_MASK8 = 7'h07;
  localparam logic [6:0] LHE_MASK128 = 7'h7F;
  localparam logic [2:0] LHE_FRLEN8 = 3'h3;
  localparam logic [2:0] LHE_FRLEN128 = 3'h5;

  // ==========================================================
  // Unnumbered codes, poll/final bit masked out
  localparam logic [7:0] LHE_U_PF_MASK = 8'hEF;
  localparam logic [7:0] LHE_U_SABM = 8'h6F;
  localparam logic [7:0] LHE_U_DISC = 8'h43;
  localparam logic [7:0] LHE_U_FRMR = 8'h87;
  localparam logic [7:0] LHE_U_UA = 8'h63;
  localparam logic [7:0] LHE_U_DM = 8'h0F;

  // Supervisory function bits
  localparam logic [1:0] LHE_S_RR = 2'h0;
  localparam logic [1:0] LHE_S_RNR = 2'h1;
  localparam logic [1:0] LHE_S_REJ = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] ctrl;
    logic is_resp;
    logic has_info;
    logic info_long;
    logic len_bad;
  } lhe_rx_frame_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic is_cmd;
    logic [39:0] info;
    logic [2:0] info_len;
  } lhe_tx_frame_s;

endpackage

// ===== lhe_peer_model.sv
/*
  Peer link terminal facing the exception handler: sends decoded
  frames and takes transmitted frames into a queue.
  Assumes the bench calls send and reads txq by hierarchy.
*/
module lhe_peer_model
  import lhe_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  output logic rx_valid_o,
  output lhe_rx_frame_s rx_frame_o,
  input wire logic tx_valid_i,
  input wire lhe_tx_frame_s tx_frame_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  lhe_tx_frame_s txq[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
    tx_ready_o = 1'b0;
  end
  // ==========================================================
  // Sink with random stalls, held frame taken on ready
  always @(posedge clk_i) begin
    tx_ready_o <= ~stall_i;
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) txq.push_back(tx_frame_i);
  end
  // ==========================================================
  // One-cycle frame; idle bus inverted so stale data never looks valid
  task automatic send(input logic [15:0] c, input logic r,
      input logic [2:0] fl);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= {c, r, fl};
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~{c, r, fl};
  endtask
endmodule

// ===== tb_top.sv
/*
  Self-checking bench for the link exception handler.
  Assumes the peer model is compiled first; one 50 MHz clock.
*/
module tb_top;
  import lhe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals and model state
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0, wr = 1'b0, t1 = 1'b0, stall = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, st;
  logic [31:0] rnd = 32'hF6C7;
  logic wreq, rxv, txv, txr, acc, rs;
  logic [6:0] rsns, last_ns = 7'h0;
  lhe_rx_frame_s rxf;
  lhe_tx_frame_s txf, got, ef;
  int failures = 0, n_tests = 0, n_acc = 0, n_rs = 0, vs = 0, vr = 0;
  logic [7:0] dis[3] = '{8'h11, 8'h7F, 8'h53};
  // Rejected ctrl, C/R, flags {info,long,len}, expected {Z,Y,X,W}
  logic [15:0] rj[7] = '{16'hEF01, 16'h0113, 16'h4343, 16'h0064,
    16'h6188, 16'h6381, 16'h1181};

  always #10 clk = ~clk;

  lhe_exception_handler i_lhe_exception_handler (.clk_sys_i(clk),
    .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .rx_valid_i(rxv), .rx_frame_i(rxf),
    .t1_expire_i(t1), .tx_valid_o(txv), .tx_ready_i(txr),
    .tx_frame_o(txf), .rx_accept_o(acc), .resend_o(rs),
    .resend_ns_o(rsns));

  lhe_peer_model i_lhe_peer_model (.clk_i(clk), .stall_i(stall),
    .rx_valid_o(rxv), .rx_frame_o(rxf), .tx_valid_i(txv),
    .tx_frame_i(txf), .tx_ready_o(txr));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // ==========================================================
  // Random stalls and pulse monitors
  always @(posedge clk) begin
    rnd <= xs(rnd);
    stall <= rnd[0] & rnd[1];
    if (acc === 1'b1) n_acc <= n_acc + 1;
    if (rs === 1'b1) begin
      n_rs <= n_rs + 1;
      last_ns <= rsns;
    end
  end

  // ==========================================================
  // Compare, bus and frame tasks
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_frame(input lhe_tx_frame_s g, input lhe_tx_frame_s e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    // No cycle count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    st = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic snd(input logic [15:0] c, input logic r,
      input logic [2:0] fl);
    i_lhe_peer_model.txq.delete();
    i_lhe_peer_model.send(c, r, fl);
    repeat (4) @(posedge clk);
  endtask

  // Last frame sent after things settle; FRMR may repeat
  task automatic expect_frame(input lhe_tx_frame_s e);
    int n;
    n = 0;
    while (i_lhe_peer_model.txq.size() == 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    if (i_lhe_peer_model.txq.size() == 0) got = '1;
    else got = i_lhe_peer_model.txq[$];
    chk_frame(got, e);
    i_lhe_peer_model.txq.delete();
  endtask

  function automatic lhe_tx_frame_s frmr(input logic [7:0] c,
      input logic cr, input logic [3:0] f, input logic m);
    logic [39:0] i;
    if (m) i = {4'h0, f, vr[6:0], cr, vs[6:0], 1'b0, 8'h00, c};
    else i = {16'h0, 4'h0, f, vr[2:0], cr, vs[2:0], 1'b0, c};
    return '{{8'h00, LHE_U_FRMR}, 1'b0, i, m ? LHE_FRLEN128 : LHE_FRLEN8};
  endfunction

  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, LHE_REG_CTRL, 32'h0);
    chk_word(st, LHE_CTRL_RESET);
    bus(1'b0, LHE_REG_STAT, 32'h0);
    chk_word(st, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk_word(st, 32'h0);
    snd(16'h006F, 1'b0, 3'b000);
    expect_frame('{16'h000F, 1'b0, 40'h0, 3'h0});
    foreach (dis[i]) begin
      snd({8'h00, dis[i]}, 1'b0, 3'b000);
      expect_frame('{16'h001F, 1'b0, 40'h0, 3'h0});
    end
    // Linked, modulo 8, window of 7
    bus(1'b1, LHE_REG_CTRL, 32'h0000_0702);
    foreach (rj[i]) begin
      snd({8'h00, rj[i][15:8]}, rj[i][7], rj[i][6:4]);
      ef = frmr(rj[i][15:8], rj[i][7], rj[i][3:0], 1'b0);
      expect_frame(ef);
      bus(1'b0, LHE_REG_STAT, 32'h0);
      chk_word(st & 32'h0100_0000, 32'h0100_0000);
      if (i == 0) begin
        snd(16'h0000, 1'b0, 3'b100);
        chk_word(n_acc, 0);
        // Polled I frame in reject condition: same reason, F set
        snd(16'h0010, 1'b0, 3'b000);
        ef.ctrl = 16'h0097;
        expect_frame(ef);
      end
      bus(1'b1, LHE_REG_CMD, 32'h1 << LHE_CMD_FRCLR);
    end
    // Sequence error: N(S)=0 in, N(S)=2 out of order, N(S)=1 in
    snd(16'h0000, 1'b0, 3'b100);
    vr = 1;
    snd(16'h0004, 1'b0, 3'b100);
    bus(1'b0, LHE_REG_STAT, 32'h0);
    chk_word(st & 32'h0200_7F00, 32'h0200_0100);
    snd(16'h0002, 1'b0, 3'b100);
    vr = 2;
    bus(1'b0, LHE_REG_STAT, 32'h0);
    chk_word(st & 32'h0200_7F00, 32'h0000_0200);
    chk_word(n_acc, 2);
    // Three frames out, then REJ from N(R)=1
    repeat (3) bus(1'b1, LHE_REG_CMD, 32'h1 << LHE_CMD_ISENT);
    vs = 3;
    bus(1'b0, LHE_REG_STAT, 32'h0);
    chk_word(st & 32'h007F_007F, 32'h0000_0003);
    snd(16'h0029, 1'b1, 3'b000);
    chk_word(n_rs, 1);
    chk_word({25'h0, last_ns}, 32'h1);
    vs = 1;
    bus(1'b0, LHE_REG_STAT, 32'h0);
    chk_word(st & 32'h007F_007F, 32'h0001_0001);
    // Frames 1 and 2 sent again so the time-out finds them unacked
    repeat (2) bus(1'b1, LHE_REG_CMD, 32'h1 << LHE_CMD_ISENT);
    vs = 3;
    // Time-out: enquiry RR command P=1, answer F=1 N(R)=1
    i_lhe_peer_model.txq.delete();
    @(posedge clk);
    t1 <= 1'b1;
    @(posedge clk);
    t1 <= 1'b0;
    expect_frame('{16'h0051, 1'b1, 40'h0, 3'h0});
    snd(16'h0031, 1'b1, 3'b000);
    chk_word(n_rs, 2);
    chk_word({25'h0, last_ns}, 32'h1);
    // Busy: poll gets RNR, after busy ends RR
    bus(1'b1, LHE_REG_CTRL, 32'h0000_0706);
    snd(16'h0031, 1'b0, 3'b000);
    expect_frame('{16'h0055, 1'b0, 40'h0, 3'h0});
    bus(1'b1, LHE_REG_CTRL, 32'h0000_0702);
    snd(16'h0031, 1'b0, 3'b000);
    expect_frame('{16'h0051, 1'b0, 40'h0, 3'h0});
    // Modulo 128 and busy: RNR; UA ends busy, still busy so RNR again
    bus(1'b1, LHE_REG_CTRL, 32'h0000_0707);
    expect_frame('{16'h0405, 1'b0, 40'h0, 3'h0});
    snd(16'h006F, 1'b0, 3'b000);
    repeat (8) @(posedge clk);
    got = i_lhe_peer_model.txq[0];
    chk_frame(got, '{16'h0063, 1'b0, 40'h0, 3'h0});
    expect_frame('{16'h0005, 1'b0, 40'h0, 3'h0});
    vs = 0;
    vr = 0;
    snd(16'h00EF, 1'b0, 3'b000);
    ef = frmr(8'hEF, 1'b0, 4'h1, 1'b1);
    expect_frame(ef);
    tally_and_finish();
  end
endmodule
